// ==== rtl/dtc_pin_if.sv ====
// one synchronised pin: its level and a falling edge pulse
`timescale 1ns/100ps
`default_nettype none
interface dtc_pin_if;
  logic level;
  logic fall;
  modport src (output level, output fall);
  modport dst (input level, input fall);
endinterface
`default_nettype wire

// ==== rtl/dtc_pin_sync.sv ====
// two-stage pin synchroniser with falling edge detection
`timescale 1ns/100ps
`default_nettype none
module dtc_pin_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic pin_in,
  dtc_pin_if.src pin
);
  logic meta;
  logic stable;
  logic prev;

  // the first stage feeds only the second stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta <= 1'b0;
      stable <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= pin_in;
      stable <= meta;
      prev <= stable;
    end
  end

  assign pin.level = stable;
  assign pin.fall = prev & ~stable; // R21
endmodule
`default_nettype wire

// ==== rtl/dtc_pkg.sv ====
// types shared by the dual timer block
package dtc_pkg;
  typedef logic [7:0] dtc_byte_t;
  typedef logic [1:0] dtc_mode_t;
  typedef logic [9:0] dtc_addr_t;
  typedef logic [31:0] dtc_word_t;
endpackage

// ==== rtl/dtc_prescaler.sv ====
// system clock divider giving a one-cycle tick enable
`timescale 1ns/100ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_prescaler #(
  parameter int DIVIDE = `DTC_TICK_DIVIDE
) (
  input wire logic clk_in,
  input wire logic rst_in,
  output logic tick_out
);
  localparam int CW = $clog2(DIVIDE);
  localparam logic [CW-1:0] LAST = CW'(DIVIDE - 1);
  logic [CW-1:0] count;

  initial begin
    if (DIVIDE < 2) begin
      $error("dtc_prescaler: DIVIDE must be at least 2");
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      count <= '0;
    end else if (count == LAST) begin
      count <= '0;
    end else begin
      count <= count + CW'(1);
    end
  end

  assign tick_out = (count == LAST); // R19
endmodule
`default_nettype wire

// ==== rtl/dtc_regs.svh ====
// register indices, field positions, reset values and timing counts of the dual timer block
`ifndef DTC_REGS_SVH
`define DTC_REGS_SVH

// register indices; byte address is four times the index
`define DTC_IDX_RUN_FLAGS 8'h88
`define DTC_IDX_MODE_CTRL 8'h89
`define DTC_IDX_ZERO_LOW 8'h8A
`define DTC_IDX_ONE_LOW 8'h8B
`define DTC_IDX_ZERO_HIGH 8'h8C
`define DTC_IDX_ONE_HIGH 8'h8D
`define DTC_IDX_PRESCALE 8'h8E

// timer_run_and_flags fields
`define DTC_ONE_FLAG_BIT 7
`define DTC_ONE_RUN_BIT 6
`define DTC_ZERO_FLAG_BIT 5
`define DTC_ZERO_RUN_BIT 4

// timer_mode_control fields
`define DTC_ONE_GATE_BIT 7
`define DTC_ONE_CSEL_BIT 6
`define DTC_ONE_MODE_HI 5
`define DTC_ONE_MODE_LO 4
`define DTC_ZERO_GATE_BIT 3
`define DTC_ZERO_CSEL_BIT 2
`define DTC_ZERO_MODE_HI 1
`define DTC_ZERO_MODE_LO 0

// clock_prescale_register fields
`define DTC_ONE_PRESCALE_BIT 4
`define DTC_ZERO_PRESCALE_BIT 3

// mode field codes
`define DTC_MODE_13BIT 2'h0
`define DTC_MODE_16BIT 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

// reset values
`define DTC_RESET_BYTE 8'h00

// internal tick divider
`define DTC_TICK_DIVIDE 12

`endif

// ==== rtl/dtc_top.sv ====
// two counter/timers with 13-bit, 16-bit, auto-reload and split modes behind an APB slave
//
// Behaviour
// (R1) mode 01 counts through the full 16-bit high:low pair, controlled as in mode 00
// (R2) auto-reload: low byte counts; on wrap sets overflow flag, reloads low from high
// (R3) auto-reload never changes the high byte; only software writes it
// (R4) overflow flag in auto-reload raises the interrupt request when enabled
// (R5) software loads the low byte with the start value before running auto-reload
// (R6) timer one auto-reload works like timer zero with its own bytes and bits
// (R7) split mode: timer zero low byte is a full 8-bit counter with its own controls
// (R8) split mode: timer zero high byte counts internal ticks only, ignoring select and gate
// (R9) split mode: high byte runs on timer one run bit and sets timer one flag
// (R10) timer one in mode 11 stops and holds; leaving mode 11 resumes counting
// (R11) with timer zero split, timer one counts internal ticks and sets no flag
// (R12) timer one overflow stays available as baud tick even in split mode
// (R13) timer one flag set on overflow, cleared on vectoring or by software
// (R14) gate 0: count when run bit set; gate 1: also needs gate input high
// (R15) count select 0: prescaled internal tick; 1: falling edge of count pin
// (R16) mode field: 00 13-bit, 01 16-bit, 10 auto-reload, 11 split or inactive
// (R17) count bytes readable and writable separately; bytes and mode reset to zero
// (R18) 13-bit: high byte upper eight, low bits 4..0; wrap at 0x1FFF sets flag
// (R19) internal tick is clock divided by twelve, or the clock itself when selected
// (R20) setting the run bit keeps the count; counting continues from held value
// (R21) count and gate pins synchronised; falling edge from two synchronised samples
// (R22) timer zero flag set on overflow, cleared on vectoring or by software
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_top (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire dtc_pkg::dtc_addr_t PADDR_IN,
  input wire dtc_pkg::dtc_word_t PWDATA_IN,
  output dtc_pkg::dtc_word_t PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  input wire logic COUNT_PIN_ZERO_IN,
  input wire logic COUNT_PIN_ONE_IN,
  input wire logic GATE_INPUT_ZERO_IN,
  input wire logic GATE_INPUT_ONE_IN,
  input wire logic ZERO_INT_ENABLE_IN,
  input wire logic ONE_INT_ENABLE_IN,
  input wire logic ZERO_INT_VECTOR_IN,
  input wire logic ONE_INT_VECTOR_IN,
  output logic ZERO_IRQ_OUT,
  output logic ONE_IRQ_OUT,
  output logic ONE_BAUD_TICK_OUT
);
  import dtc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  dtc_byte_t timer_mode_control;
  logic zero_prescale_select;
  logic one_prescale_select;
  logic zero_run_bit;
  logic one_run_bit;
  logic zero_overflow_flag;
  logic one_overflow_flag;
  dtc_byte_t timer_zero_low_byte;
  dtc_byte_t timer_zero_high_byte;
  dtc_byte_t timer_one_low_byte;
  dtc_byte_t timer_one_high_byte;

  ////////////////////////////////////////////////////////////////////////////
  // pins and tick

  dtc_pin_if count_pin_zero ();
  dtc_pin_if count_pin_one ();
  dtc_pin_if gate_input_zero ();
  dtc_pin_if gate_input_one ();
  logic div_tick;

  dtc_pin_sync u_sync_count_zero (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .pin_in(COUNT_PIN_ZERO_IN),
    .pin(count_pin_zero)
  );

  dtc_pin_sync u_sync_count_one (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .pin_in(COUNT_PIN_ONE_IN),
    .pin(count_pin_one)
  );

  dtc_pin_sync u_sync_gate_zero (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .pin_in(GATE_INPUT_ZERO_IN),
    .pin(gate_input_zero)
  );

  dtc_pin_sync u_sync_gate_one (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .pin_in(GATE_INPUT_ONE_IN),
    .pin(gate_input_one)
  );

  dtc_prescaler #(
    .DIVIDE(`DTC_TICK_DIVIDE)
  ) u_prescaler (
    .clk_in(CLK_IN),
    .rst_in(SYS_RST_IN),
    .tick_out(div_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // register bus decode

  logic [7:0] bus_index;
  logic bus_aligned;
  logic bus_mapped;
  logic bus_write;
  logic wr_run_flags;
  logic wr_mode_ctrl;
  logic wr_prescale;
  logic wr_zero_low;
  logic wr_zero_high;
  logic wr_one_low;
  logic wr_one_high;
  dtc_byte_t wdata;
  dtc_byte_t next_read_byte;

  assign bus_index = PADDR_IN[9:2];
  assign bus_aligned = (PADDR_IN[1:0] == 2'h0);
  assign wdata = PWDATA_IN[7:0];

  always_comb begin
    bus_mapped = bus_aligned;
    next_read_byte = 8'h00;
    case (bus_aligned ? bus_index : 8'h00) // a misaligned read falls to default and returns zero
      `DTC_IDX_RUN_FLAGS: begin
        next_read_byte[`DTC_ONE_FLAG_BIT] = one_overflow_flag;
        next_read_byte[`DTC_ONE_RUN_BIT] = one_run_bit;
        next_read_byte[`DTC_ZERO_FLAG_BIT] = zero_overflow_flag;
        next_read_byte[`DTC_ZERO_RUN_BIT] = zero_run_bit;
      end
      `DTC_IDX_MODE_CTRL: next_read_byte = timer_mode_control;
      `DTC_IDX_ZERO_LOW: next_read_byte = timer_zero_low_byte; // R17
      `DTC_IDX_ONE_LOW: next_read_byte = timer_one_low_byte; // R17
      `DTC_IDX_ZERO_HIGH: next_read_byte = timer_zero_high_byte; // R17
      `DTC_IDX_ONE_HIGH: next_read_byte = timer_one_high_byte; // R17
      `DTC_IDX_PRESCALE: begin
        next_read_byte[`DTC_ONE_PRESCALE_BIT] = one_prescale_select;
        next_read_byte[`DTC_ZERO_PRESCALE_BIT] = zero_prescale_select;
      end
      default: bus_mapped = 1'b0;
    endcase
  end

  // zero wait states: read data is captured in the setup cycle
  assign PREADY_OUT = 1'b1;
  assign PSLVERR_OUT = PSEL_IN & PENABLE_IN & ~bus_mapped;
  assign bus_write = PSEL_IN & PENABLE_IN & PWRITE_IN & bus_mapped;
  assign wr_run_flags = bus_write & (bus_index == `DTC_IDX_RUN_FLAGS);
  assign wr_mode_ctrl = bus_write & (bus_index == `DTC_IDX_MODE_CTRL);
  assign wr_prescale = bus_write & (bus_index == `DTC_IDX_PRESCALE);
  assign wr_zero_low = bus_write & (bus_index == `DTC_IDX_ZERO_LOW);
  assign wr_zero_high = bus_write & (bus_index == `DTC_IDX_ZERO_HIGH);
  assign wr_one_low = bus_write & (bus_index == `DTC_IDX_ONE_LOW);
  assign wr_one_high = bus_write & (bus_index == `DTC_IDX_ONE_HIGH);

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      PRDATA_OUT <= 32'h0000_0000;
    end else if (PSEL_IN & ~PENABLE_IN & ~PWRITE_IN) begin
      PRDATA_OUT <= {24'h00_0000, next_read_byte};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      timer_mode_control <= `DTC_RESET_BYTE; // R17
    end else if (wr_mode_ctrl) begin
      timer_mode_control <= wdata;
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      zero_prescale_select <= 1'b0;
      one_prescale_select <= 1'b0;
    end else if (wr_prescale) begin
      zero_prescale_select <= wdata[`DTC_ZERO_PRESCALE_BIT];
      one_prescale_select <= wdata[`DTC_ONE_PRESCALE_BIT];
    end
  end

  // run bits only gate counting; they never touch the count bytes
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      zero_run_bit <= 1'b0;
      one_run_bit <= 1'b0;
    end else if (wr_run_flags) begin
      zero_run_bit <= wdata[`DTC_ZERO_RUN_BIT]; // R20
      one_run_bit <= wdata[`DTC_ONE_RUN_BIT]; // R20
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // count enables

  dtc_mode_t zero_mode;
  dtc_mode_t one_mode;
  logic zero_split;
  logic zero_tick;
  logic one_tick;
  logic zero_enable;
  logic one_enable;
  logic zero_inc;
  logic one_inc;
  logic split_high_inc;

  assign zero_mode = timer_mode_control[`DTC_ZERO_MODE_HI:`DTC_ZERO_MODE_LO]; // R16
  assign one_mode = timer_mode_control[`DTC_ONE_MODE_HI:`DTC_ONE_MODE_LO]; // R16
  assign zero_split = (zero_mode == `DTC_MODE_SPLIT);
  assign zero_tick = zero_prescale_select | div_tick; // R19
  assign one_tick = one_prescale_select | div_tick; // R19

  assign zero_enable = zero_run_bit &
    (~timer_mode_control[`DTC_ZERO_GATE_BIT] | gate_input_zero.level); // R14 R7
  assign zero_inc = zero_enable &
    (timer_mode_control[`DTC_ZERO_CSEL_BIT] ? count_pin_zero.fall : zero_tick); // R15

  assign one_enable = one_run_bit &
    (~timer_mode_control[`DTC_ONE_GATE_BIT] | gate_input_one.level); // R14

  always_comb begin
    if (one_mode == `DTC_MODE_SPLIT) begin
      one_inc = 1'b0; // R10
    end else if (zero_split) begin
      // timer one lost its run bit to the split high byte, so it free-runs on ticks
      one_inc = one_tick; // R11
    end else begin
      one_inc = one_enable &
        (timer_mode_control[`DTC_ONE_CSEL_BIT] ? count_pin_one.fall : one_tick); // R15 R6
    end
  end

  assign split_high_inc = zero_split & one_run_bit & zero_tick; // R8 R9

  ////////////////////////////////////////////////////////////////////////////
  // count step: returns {overflow, high, low}

  function automatic logic [16:0] count_step(input dtc_mode_t mode, input dtc_byte_t high,
                                             input dtc_byte_t low);
    logic [5:0] low5;
    logic [16:0] wide;
    logic [8:0] low9;
    low5 = {1'b0, low[4:0]} + 6'h01;
    wide = {1'b0, high, low} + 17'h0_0001;
    low9 = {1'b0, low} + 9'h001;
    case (mode)
      `DTC_MODE_13BIT: begin
        // upper three low bits are left alone and carry nothing
        if (low5[5]) begin
          count_step = {(high == 8'hFF), 8'(high + 8'h01), low[7:5], low5[4:0]}; // R18
        end else begin
          count_step = {1'b0, high, low[7:5], low5[4:0]};
        end
      end
      `DTC_MODE_16BIT: count_step = wide; // R1
      `DTC_MODE_RELOAD: begin
        if (low9[8]) begin
          count_step = {1'b1, high, high}; // R2 R3
        end else begin
          count_step = {1'b0, high, low9[7:0]};
        end
      end
      default: count_step = {low9[8], high, low9[7:0]}; // R7
    endcase
  endfunction

  logic [16:0] zero_step;
  logic [16:0] one_step;
  logic zero_overflow;
  logic one_overflow;
  logic split_high_overflow;

  assign zero_step = count_step(zero_mode, timer_zero_high_byte, timer_zero_low_byte);
  assign one_step = count_step(one_mode, timer_one_high_byte, timer_one_low_byte);
  assign zero_overflow = zero_inc & zero_step[16];
  assign one_overflow = one_inc & one_step[16];
  assign split_high_overflow = split_high_inc & (timer_zero_high_byte == 8'hFF);

  ////////////////////////////////////////////////////////////////////////////
  // count bytes; a software write wins over a count in the same cycle

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      timer_zero_low_byte <= `DTC_RESET_BYTE; // R17
    end else if (wr_zero_low) begin
      timer_zero_low_byte <= wdata;
    end else if (zero_inc) begin
      timer_zero_low_byte <= zero_step[7:0]; // R2 R7
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      timer_zero_high_byte <= `DTC_RESET_BYTE; // R17
    end else if (wr_zero_high) begin
      timer_zero_high_byte <= wdata; // R3
    end else if (split_high_inc) begin
      timer_zero_high_byte <= timer_zero_high_byte + 8'h01; // R8
    end else if (zero_inc & ~zero_split) begin
      timer_zero_high_byte <= zero_step[15:8]; // R1 R18
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      timer_one_low_byte <= `DTC_RESET_BYTE; // R17
    end else if (wr_one_low) begin
      timer_one_low_byte <= wdata;
    end else if (one_inc) begin
      timer_one_low_byte <= one_step[7:0]; // R6
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      timer_one_high_byte <= `DTC_RESET_BYTE; // R17
    end else if (wr_one_high) begin
      timer_one_high_byte <= wdata; // R3
    end else if (one_inc) begin
      timer_one_high_byte <= one_step[15:8]; // R6
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // overflow flags: hardware set beats vectoring clear and software write

  logic zero_flag_set;
  logic one_flag_set;

  assign zero_flag_set = zero_overflow; // R22
  assign one_flag_set = zero_split ? split_high_overflow : one_overflow; // R9 R11 R13

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      zero_overflow_flag <= 1'b0;
    end else if (zero_flag_set) begin
      zero_overflow_flag <= 1'b1; // R22 R2
    end else if (wr_run_flags) begin
      zero_overflow_flag <= wdata[`DTC_ZERO_FLAG_BIT]; // R22
    end else if (ZERO_INT_VECTOR_IN) begin
      zero_overflow_flag <= 1'b0; // R22
    end
  end

  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      one_overflow_flag <= 1'b0;
    end else if (one_flag_set) begin
      one_overflow_flag <= 1'b1; // R13
    end else if (wr_run_flags) begin
      one_overflow_flag <= wdata[`DTC_ONE_FLAG_BIT]; // R13
    end else if (ONE_INT_VECTOR_IN) begin
      one_overflow_flag <= 1'b0; // R13
    end
  end

  assign ZERO_IRQ_OUT = zero_overflow_flag & ZERO_INT_ENABLE_IN; // R4
  assign ONE_IRQ_OUT = one_overflow_flag & ONE_INT_ENABLE_IN; // R4 R9

  // baud tick follows timer one whether or not its flag may be set
  always_ff @(posedge CLK_IN or posedge SYS_RST_IN) begin
    if (SYS_RST_IN) begin
      ONE_BAUD_TICK_OUT <= 1'b0;
    end else begin
      ONE_BAUD_TICK_OUT <= one_overflow; // R12
    end
  end
endmodule
`default_nettype wire

// ==== tb/dtc_core_model.sv ====
// processor core stand-in that vectors to a pending timer interrupt
`timescale 1ns/100ps
`default_nettype none
module dtc_core_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic irq_in,
  input wire logic take_in,
  output logic vector_out
);
  // one pulse per request; the flag clears behind it, so no second pulse follows
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      vector_out <= 1'b0;
    end else begin
      vector_out <= take_in && irq_in && !vector_out;
    end
  end
endmodule
`default_nettype wire

// ==== tb/dtc_top_assertions.sv ====
// concurrent checks on the dual timer top-level ports
`timescale 1ns/100ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_top_assertions (
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire dtc_pkg::dtc_addr_t PADDR_IN,
  input wire dtc_pkg::dtc_word_t PRDATA_OUT,
  input wire logic PREADY_OUT,
  input wire logic PSLVERR_OUT,
  input wire logic ZERO_INT_ENABLE_IN,
  input wire logic ONE_INT_ENABLE_IN,
  input wire logic ZERO_INT_VECTOR_IN,
  input wire logic ONE_INT_VECTOR_IN,
  input wire logic ZERO_IRQ_OUT,
  input wire logic ONE_IRQ_OUT
);
  import dtc_pkg::*;
  logic acc;
  logic map;
  logic flag_wr;
  assign acc = PSEL_IN && PENABLE_IN;
  assign map = PADDR_IN[1:0] == 2'b00 && PADDR_IN[9:2] >= `DTC_IDX_RUN_FLAGS && PADDR_IN[9:2] <= `DTC_IDX_PRESCALE;
  // software may rewrite the flags, so a flag only has to persist when no such write lands
  assign flag_wr = acc && PWRITE_IN && PADDR_IN == {`DTC_IDX_RUN_FLAGS, 2'b00};
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  ready_high_a:
  assert property (PREADY_OUT) else $error("pready low");
  err_unmapped_a:
  assert property (acc && !map |-> PSLVERR_OUT) else $error("no error on unmapped access");
  err_spurious_a:
  assert property (PSLVERR_OUT |-> acc && !map) else $error("error on mapped access or outside access");
  rdata_unmapped_a:
  assert property (PSEL_IN && !PENABLE_IN && !PWRITE_IN && !map |=> PRDATA_OUT == 32'h0000_0000)
    else $error("unmapped read not zero");
  rdata_upper_a:
  assert property (PRDATA_OUT[31:8] == 24'h00_0000) else $error("upper read data not zero");
  rdata_hold_a:
  assert property (!(PSEL_IN && !PENABLE_IN && !PWRITE_IN) |=> $stable(PRDATA_OUT)) else $error("read data moved");
  zero_irq_mask_a:
  assert property (!ZERO_INT_ENABLE_IN |-> !ZERO_IRQ_OUT) else $error("zero irq while disabled");
  one_irq_mask_a:
  assert property (!ONE_INT_ENABLE_IN |-> !ONE_IRQ_OUT) else $error("one irq while disabled");
  zero_flag_hold_a:
  assert property (ZERO_IRQ_OUT && !ZERO_INT_VECTOR_IN && !flag_wr ##1 ZERO_INT_ENABLE_IN |-> ZERO_IRQ_OUT)
    else $error("zero flag dropped");
  one_flag_hold_a:
  assert property (ONE_IRQ_OUT && !ONE_INT_VECTOR_IN && !flag_wr ##1 ONE_INT_ENABLE_IN |-> ONE_IRQ_OUT)
    else $error("one flag dropped");
endmodule
bind dtc_top dtc_top_assertions dtc_top_assertions_inst (.CLK_IN(CLK_IN), .SYS_RST_IN(SYS_RST_IN),
  .PSEL_IN(PSEL_IN), .PENABLE_IN(PENABLE_IN), .PWRITE_IN(PWRITE_IN), .PADDR_IN(PADDR_IN),
  .PRDATA_OUT(PRDATA_OUT), .PREADY_OUT(PREADY_OUT), .PSLVERR_OUT(PSLVERR_OUT),
  .ZERO_INT_ENABLE_IN(ZERO_INT_ENABLE_IN), .ONE_INT_ENABLE_IN(ONE_INT_ENABLE_IN),
  .ZERO_INT_VECTOR_IN(ZERO_INT_VECTOR_IN), .ONE_INT_VECTOR_IN(ONE_INT_VECTOR_IN),
  .ZERO_IRQ_OUT(ZERO_IRQ_OUT), .ONE_IRQ_OUT(ONE_IRQ_OUT));
`default_nettype wire

// ==== tb/dtc_top_tb.sv ====
// self-checking bench for the dual timer block
`timescale 1ns/100ps
`default_nettype none
`include "dtc_regs.svh"
module dtc_top_tb;
  import dtc_pkg::*;
  localparam dtc_byte_t rf = `DTC_IDX_RUN_FLAGS;
  localparam dtc_byte_t mc = `DTC_IDX_MODE_CTRL;
  localparam dtc_byte_t zl = `DTC_IDX_ZERO_LOW;
  localparam dtc_byte_t ol = `DTC_IDX_ONE_LOW;
  localparam dtc_byte_t zh = `DTC_IDX_ZERO_HIGH;
  localparam dtc_byte_t oh = `DTC_IDX_ONE_HIGH;
  localparam dtc_byte_t ps = `DTC_IDX_PRESCALE;
  logic clk, rst, psel, pen, pwr, pready, pslverr, cp0, cp1, g0, g1;
  logic en0, en1, vec0, vec1, irq0, irq1, baud, take0, take1;
  dtc_addr_t paddr;
  dtc_word_t pwdata, prdata;
  dtc_byte_t q_exp[$], q_msk[$], m, r;
  dtc_byte_t regs[7] = '{rf, mc, zl, ol, zh, oh, ps};
  int fail_count, n_compared, baud_n, n;
  bit got;
  dtc_top dtc_top_inst (.CLK_IN(clk), .SYS_RST_IN(rst), .PSEL_IN(psel), .PENABLE_IN(pen), .PWRITE_IN(pwr),
    .PADDR_IN(paddr), .PWDATA_IN(pwdata), .PRDATA_OUT(prdata), .PREADY_OUT(pready), .PSLVERR_OUT(pslverr),
    .COUNT_PIN_ZERO_IN(cp0), .COUNT_PIN_ONE_IN(cp1), .GATE_INPUT_ZERO_IN(g0), .GATE_INPUT_ONE_IN(g1),
    .ZERO_INT_ENABLE_IN(en0), .ONE_INT_ENABLE_IN(en1), .ZERO_INT_VECTOR_IN(vec0), .ONE_INT_VECTOR_IN(vec1),
    .ZERO_IRQ_OUT(irq0), .ONE_IRQ_OUT(irq1), .ONE_BAUD_TICK_OUT(baud));
  dtc_core_model dtc_core_model_inst (.clk_in(clk), .rst_in(rst), .irq_in(irq0), .take_in(take0),
    .vector_out(vec0));
  dtc_core_model dtc_core_model_one_inst (.clk_in(clk), .rst_in(rst), .irq_in(irq1), .take_in(take1),
    .vector_out(vec1));
  ////////////////////////////////////////////////////////////
  task automatic check(input string what, input dtc_byte_t seen, input dtc_byte_t exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // for a read, d is the expected byte; an idle cycle follows so psel is never reassigned at once
  task automatic apb(input bit wr, input dtc_byte_t idx, input dtc_byte_t d, input dtc_byte_t msk = 8'hFF);
    if (!wr) begin
      q_exp.push_back(d & msk);
      q_msk.push_back(msk);
    end
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h00_0000, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_irq(input bit one, output bit hit);
    hit = 0;
    for (int i = 0; i < 600 && !hit; i++) begin
      @(posedge clk);
      hit = (one ? irq1 : irq0) === 1'b1;
    end
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    if (baud === 1'b1) baud_n++;
    if (psel && pen && !pwr && pready === 1'b1) begin
      m = q_msk.pop_front();
      check("read data", prdata[7:0] & m, q_exp.pop_front());
    end
  end
  initial begin
    #100000;
    fail_count++;
    close_out();
  end
  initial begin
    {psel, pen, pwr, paddr, pwdata, g0, g1, en0, en1, take0, take1} = '0;
    {cp0, cp1} = 2'b11;
    rst = 1;
    void'($urandom(88845));
    repeat (2) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    for (int i = 0; i < 7; i++) apb(0, regs[i], 8'h00);
    apb(0, 8'h8F, 8'h00);
    for (int i = 1; i < 7; i++) begin
      // timer zero kept out of split mode here, or timer one would free-run under the readback
      r = 8'($urandom) & (i == 1 ? 8'hFE : 8'hFF);
      apb(1, regs[i], r);
      apb(0, regs[i], i == 6 ? r & 8'h18 : r);
    end
    apb(1, rf, 8'h0F);
    apb(0, rf, 8'h00);
    // divide by twelve: 120 counted edges give exactly ten ticks
    apb(1, ps, 8'h00);
    apb(1, mc, 8'h01);
    apb(1, zl, 8'h00);
    apb(1, zh, 8'h00);
    apb(1, rf, 8'h10);
    repeat (117) @(posedge clk);
    apb(1, rf, 8'h00);
    apb(0, zl, 8'h0A);
    apb(1, ps, 8'h18);
    apb(1, zh, 8'hFF);
    apb(1, zl, 8'hF0);
    en0 <= 1;
    apb(1, rf, 8'h10);
    wait_irq(0, got);
    check("zero wrap", got, 1);
    apb(1, rf, 8'h20);
    apb(0, zh, 8'h00);
    take0 <= 1;
    repeat (3) @(posedge clk);
    check("zero vector clear", irq0, 0);
    take0 <= 0;
    apb(1, zh, 8'hFF);
    apb(1, zl, 8'h1C);
    apb(1, mc, 8'h00);
    apb(1, rf, 8'h10);
    wait_irq(0, got);
    check("thirteen wrap", got, 1);
    apb(1, rf, 8'h00);
    apb(0, zh, 8'h00);
    apb(0, zl, 8'h00, 8'hF8);
    check("zero soft clear", irq0, 0);
    apb(1, mc, 8'h09);
    apb(1, zl, 8'h10);
    apb(1, rf, 8'h10);
    repeat (20) @(posedge clk);
    apb(0, zl, 8'h10);
    g0 <= 1;
    repeat (20) @(posedge clk);
    apb(1, rf, 8'h00);
    apb(0, zl, 8'h20, 8'hF0);
    g0 <= 0;
    apb(1, mc, 8'h05);
    apb(1, zl, 8'h00);
    apb(1, rf, 8'h10);
    n = $urandom_range(8, 1);
    repeat (n) begin
      cp0 <= 0;
      repeat (4) @(posedge clk);
      cp0 <= 1;
      repeat (4) @(posedge clk);
    end
    repeat (4) @(posedge clk);
    apb(1, rf, 8'h00);
    apb(0, zl, n[7:0]);
    en1 <= 1;
    apb(1, mc, 8'h20);
    apb(1, oh, 8'hF0);
    apb(1, ol, 8'hFC);
    n = baud_n;
    apb(1, rf, 8'h40);
    wait_irq(1, got);
    check("one reload flag", got, 1);
    apb(1, rf, 8'h80);
    apb(0, oh, 8'hF0);
    apb(0, ol, 8'hF0, 8'hF0);
    check("baud tick", baud_n > n, 1);
    take1 <= 1;
    repeat (3) @(posedge clk);
    check("one vector clear", irq1, 0);
    take1 <= 0;
    apb(1, mc, 8'h30);
    apb(1, ol, 8'h33);
    apb(1, rf, 8'h40);
    repeat (30) @(posedge clk);
    apb(0, ol, 8'h33);
    apb(1, mc, 8'h10);
    repeat (14) @(posedge clk);
    apb(1, rf, 8'h00);
    apb(0, ol, 8'h40, 8'hF0);
    // split mode: gate and count select set on timer zero must not hold the high byte back
    apb(1, zl, 8'h55);
    apb(1, zh, 8'hF0);
    apb(1, mc, 8'hFF);
    apb(1, rf, 8'h40);
    wait_irq(1, got);
    check("split high flag", got, 1);
    apb(0, zl, 8'h55);
    apb(1, rf, 8'h00);
    apb(1, oh, 8'hFF);
    apb(1, ol, 8'hF0);
    n = baud_n;
    apb(1, mc, 8'h13);
    repeat (60) @(posedge clk);
    check("split one no flag", irq1, 0);
    check("split baud tick", baud_n > n, 1);
    close_out();
  end
endmodule
`default_nettype wire
